// ---- src/orxid_pkg.sv ----
package orxid_pkg;
   // Byte offsets in the management address space
   localparam logic [7:0] PAGE_SEL_ADDR      = 8'h7f;
   localparam logic [7:0] UPPER_BASE         = 8'h80;
   localparam logic [7:0] PAGE_SEL_RESET     = 8'h00;
   localparam logic [7:0] PAGE_ID_P0         = 8'h00;
   localparam logic [7:0] PAGE_ID_P1         = 8'h01;
   // Upper page 00h layout
   localparam logic [7:0] P0_POWER_CLASS     = 8'h81;
   localparam logic [7:0] P0_CONNECTOR       = 8'h82;
   localparam logic [7:0] P0_SUPPLY          = 8'h83;
   localparam logic [7:0] P0_MAX_TEMP        = 8'h84;
   localparam logic [7:0] P0_MIN_RATE        = 8'h85;
   localparam logic [7:0] P0_MAX_RATE        = 8'h86;
   localparam logic [7:0] P0_WAVE_HI         = 8'h87;
   localparam logic [7:0] P0_WAVE_LO         = 8'h88;
   localparam logic [7:0] P0_TOL_HI          = 8'h89;
   localparam logic [7:0] P0_TOL_LO          = 8'h8a;
   localparam logic [7:0] P0_SIG_FLAGS       = 8'h8b;
   localparam logic [7:0] P0_MON_FLAGS       = 8'h8c;
   localparam logic [7:0] P0_XMON_FLAGS      = 8'h8d;
   localparam logic [7:0] P0_LANE_CAPS       = 8'h90;
   localparam logic [7:0] P0_TECH            = 8'h93;
   localparam logic [7:0] P0_MAX_POWER       = 8'h94;
   localparam logic [7:0] P0_RATES           = 8'h95;
   localparam logic [7:0] P0_LEN_HI          = 8'h96;
   localparam logic [7:0] P0_LEN_LO          = 8'h97;
   localparam logic [7:0] P0_NAME            = 8'h98;
   localparam logic [7:0] P0_OUI             = 8'ha8;
   localparam logic [7:0] P0_PART            = 8'hab;
   localparam logic [7:0] P0_REV             = 8'hbb;
   localparam logic [7:0] P0_SERIAL          = 8'hbd;
   localparam logic [7:0] P0_DATE            = 8'hcd;
   localparam logic [7:0] P0_LOT             = 8'hd5;
   localparam logic [7:0] P0_CHECKSUM        = 8'hdf;
   localparam logic [7:0] P0_RSVD_BASE       = 8'he0;
   // Upper page 01h layout
   localparam logic [7:0] P1_TEMP_HI         = 8'h80;
   localparam logic [7:0] P1_TEMP_LO         = 8'h82;
   localparam logic [7:0] P1_VCC_HI_MSB      = 8'h90;
   localparam logic [7:0] P1_VCC_HI_LSB      = 8'h91;
   localparam logic [7:0] P1_VCC_LO_MSB      = 8'h92;
   localparam logic [7:0] P1_VCC_LO_LSB      = 8'h93;
   localparam logic [7:0] P1_CSUM_MSB        = 8'hb4;
   localparam logic [7:0] P1_CSUM_LSB        = 8'hb5;
   localparam logic [7:0] P1_RSVD_BASE       = 8'hb6;
   // Field values
   localparam logic [2:0] POWER_CLASS_3      = 3'h3;
   localparam logic [7:0] CONN_AOC           = 8'h32;
   localparam logic [7:0] CONN_PIGTAIL       = 8'h81;
   localparam logic [7:0] SUPPLY_3V3         = 8'h80;
   localparam logic [7:0] MAX_TEMP_VAL       = 8'h46;
   localparam logic [7:0] MAX_RATE_VAL       = 8'h8d;
   localparam logic [7:0] WAVE_HI_VAL        = 8'h42;
   localparam logic [7:0] WAVE_LO_VAL        = 8'h68;
   localparam logic [7:0] TOL_HI_VAL         = 8'h07;
   localparam logic [7:0] TOL_LO_VAL         = 8'hd0;
   localparam logic [7:0] SIG_FLAGS_VAL      = 8'h50;
   localparam logic [7:0] MON_FLAGS_VAL      = 8'h1b;
   localparam logic [7:0] XMON_FLAGS_VAL     = 8'h20;
   localparam logic [7:0] LANE_CAPS_VAL      = 8'ha0;
   localparam logic [3:0] TECH_VCSEL         = 4'h0;
   localparam logic       DETECTOR_PIN       = 1'b0;
   localparam logic [7:0] MAX_POWER_VAL      = 8'h12;
   localparam logic [7:0] RATES_VAL          = 8'h9e;
   localparam logic [7:0] ASCII_SPACE        = 8'h20;
   localparam logic [7:0] RESERVED_FILL      = 8'hff;
   localparam logic [7:0] ZERO_BYTE          = 8'h00;
   localparam int         NAME_LEN           = 16;
   localparam int         PART_LEN           = 16;
   localparam int         REV_LEN            = 2;
   localparam int         SERIAL_LEN         = 16;
   localparam int         DATE_LEN           = 8;
   localparam int         LOT_LEN            = 10;
   localparam int         P0_SUM_LEN         = 95;
   localparam int         P1_SUM_LEN         = 52;
   localparam logic [7:0] P1_TEMP_HI_VAL     = 8'h46;
   localparam logic [7:0] P1_TEMP_LO_VAL     = 8'h00;
   localparam logic [15:0] P1_VCC_HI_VAL     = 16'h875a;
   localparam logic [15:0] P1_VCC_LO_VAL     = 16'h7a76;
   // Alarm flag bit positions in the flag/mask words
   localparam int         ALM_TEMP_HI        = 3;
   localparam int         ALM_TEMP_LO        = 2;
   localparam int         ALM_VCC_HI         = 1;
   localparam int         ALM_VCC_LO         = 0;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } orxid_req_t;

   typedef struct packed {
      logic [7:0] caseTemp;
      logic [15:0] supplyVolt;
   } orxid_mon_t;

   typedef enum logic [1:0] {
      ORXID_IDLE = 2'b01,
      ORXID_RESP = 2'b10
   } orxid_state_t;
endpackage

// ---- src/orxid_page_map.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Page select byte sits at lower address 127 and resets to zero.
// - Upper page 00h bytes are read-only; writes leave them unchanged.
// - Byte 129 bits 7..5 report power class, this device reports 011b.
// - Byte 130 holds connector code, 32h optical cable or 81h pigtail.
// - Byte 132 reads 46h case temperature; byte 131 bit 7 reads 1.
// - Byte 134 reads 8Dh max lane rate; byte 133 minimum rate.
// - Bytes 135..136 hold wavelength times twenty, 42h then 68h.
// - Bytes 137..138 hold tolerance times two hundred, 07h then D0h.
// - Bytes 139..144 hold feature flags, one means supported.
// - Byte 148 reads 12h max power; byte 147 VCSEL and PIN detector.
// - Byte 149 flags supported data rates per fixed bit pattern.
// - Bytes 150..151 hold cable length in half-metre steps.
// - Vendor text fields are ASCII, left-aligned, space padded.
// - Bytes 168..170 hold three-byte vendor company identifier.
// - Date code is ASCII digits year, month, day.
// - Byte 223 is low eight bits of sum of bytes 128..222.
// - Page 00h bytes 224..255 read back FFh.
// - Page 01h holds read-only thresholds; crossings raise module alarms.
// - Page 01h temp thresholds at 128 and 130, supply at 144..147.
// - Unmasked module alarm drives the active-low interrupt output.
// - Mask bit set keeps its latched flag off the interrupt; masks are an input, not reset.
// - Page 01h bytes 180..181 hold low sixteen bits of sum 128..179.
module orxid_page_map
   import orxid_pkg::*;
#(
   parameter logic [23:0]   VENDOR_COMPANY_ID    = 24'h123456,          // Arbitrary value
   parameter logic [15:0]   CABLE_LEN     = 16'h0002,
   parameter logic [7:0]    CONNECTOR     = CONN_AOC,
   parameter logic [7:0]    MIN_RATE      = 8'h19,
   parameter logic [8*16-1:0] VENDOR_NAME = "ACME OPTICS     ",  // Arbitrary value
   parameter logic [8*16-1:0] PART_NUM    = "RX12-GENERIC    ",  // Arbitrary value
   parameter logic [8*2-1:0]  REVISION    = "01",
   parameter logic [8*16-1:0] SERIAL_NUM  = "SN0000000001    ",
   parameter logic [8*8-1:0]  DATE_CODE   = "20240101",
   parameter logic [8*10-1:0] LOT_CODE    = "LOT0001   "
)(
   input  wire logic       clk,              // 40 MHz clock
   input  wire logic       srst,             // Synchronous reset, active high
   input  wire orxid_req_t req,              // Byte access request
   input  wire orxid_mon_t mon,              // Live monitor values
   input  wire logic [3:0] alarmMask,        // Mask bits, 1 blocks flag from interrupt
   input  wire logic [3:0] alarmClear,       // Clear pulses for latched flags
   output logic [7:0]      rdData,           // Read data, registered
   output logic            rdValid,          // Read data valid pulse
   output logic [7:0]      pageSel,          // Current page select value
   output logic [3:0]      alarmFlags,       // Latched module alarm flags
   output logic            alarm_interrupt_low // Interrupt to host, active low
);

   function automatic logic [7:0] textByte(input logic [8*16-1:0] s, input int len, input int idx);
      logic [7:0] b;
      b = s[8*(len-1-idx) +: 8];
      // Space padding replaces any NUL left by short strings
      textByte = (b == ZERO_BYTE) ? ASCII_SPACE : b;
   endfunction

   function automatic logic inRange(input logic [7:0] a, input logic [7:0] base, input int len);
      inRange = (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(len)));
   endfunction

   function automatic logic [7:0] page0Raw(input logic [7:0] a);
      int i;
      i = int'(a);
      page0Raw = ZERO_BYTE;
      if (inRange(a, P0_NAME, NAME_LEN))
         page0Raw = textByte(VENDOR_NAME, NAME_LEN, i - int'(P0_NAME));
      else if (inRange(a, P0_OUI, 3))
         page0Raw = VENDOR_COMPANY_ID[8*(2-(i-int'(P0_OUI))) +: 8];
      else if (inRange(a, P0_PART, PART_LEN))
         page0Raw = textByte(PART_NUM, PART_LEN, i - int'(P0_PART));
      else if (inRange(a, P0_REV, REV_LEN))
         page0Raw = textByte({112'h0, REVISION}, REV_LEN, i - int'(P0_REV));
      else if (inRange(a, P0_SERIAL, SERIAL_LEN))
         page0Raw = textByte(SERIAL_NUM, SERIAL_LEN, i - int'(P0_SERIAL));
      else if (inRange(a, P0_DATE, DATE_LEN))
         page0Raw = textByte({64'h0, DATE_CODE}, DATE_LEN, i - int'(P0_DATE));
      else if (inRange(a, P0_LOT, LOT_LEN))
         page0Raw = textByte({48'h0, LOT_CODE}, LOT_LEN, i - int'(P0_LOT));
      else begin
         case (a)
            P0_POWER_CLASS: page0Raw = {POWER_CLASS_3, 5'h00};
            P0_CONNECTOR:   page0Raw = CONNECTOR;
            P0_SUPPLY:      page0Raw = SUPPLY_3V3;
            P0_MAX_TEMP:    page0Raw = MAX_TEMP_VAL;
            P0_MIN_RATE:    page0Raw = MIN_RATE;
            P0_MAX_RATE:    page0Raw = MAX_RATE_VAL;
            P0_WAVE_HI:     page0Raw = WAVE_HI_VAL;
            P0_WAVE_LO:     page0Raw = WAVE_LO_VAL;
            P0_TOL_HI:      page0Raw = TOL_HI_VAL;
            P0_TOL_LO:      page0Raw = TOL_LO_VAL;
            P0_SIG_FLAGS:   page0Raw = SIG_FLAGS_VAL;
            P0_MON_FLAGS:   page0Raw = MON_FLAGS_VAL;
            P0_XMON_FLAGS:  page0Raw = XMON_FLAGS_VAL;
            P0_LANE_CAPS:   page0Raw = LANE_CAPS_VAL;
            P0_TECH:        page0Raw = {TECH_VCSEL, 2'b00, DETECTOR_PIN, 1'b0};
            P0_MAX_POWER:   page0Raw = MAX_POWER_VAL;
            P0_RATES:       page0Raw = RATES_VAL;
            P0_LEN_HI:      page0Raw = CABLE_LEN[15:8];
            P0_LEN_LO:      page0Raw = CABLE_LEN[7:0];
            default:        page0Raw = ZERO_BYTE;
         endcase
      end
   endfunction

   function automatic logic [7:0] page1Raw(input logic [7:0] a);
      case (a)
         P1_TEMP_HI:    page1Raw = P1_TEMP_HI_VAL;
         P1_TEMP_LO:    page1Raw = P1_TEMP_LO_VAL;
         P1_VCC_HI_MSB: page1Raw = P1_VCC_HI_VAL[15:8];
         P1_VCC_HI_LSB: page1Raw = P1_VCC_HI_VAL[7:0];
         P1_VCC_LO_MSB: page1Raw = P1_VCC_LO_VAL[15:8];
         P1_VCC_LO_LSB: page1Raw = P1_VCC_LO_VAL[7:0];
         default:       page1Raw = ZERO_BYTE;
      endcase
   endfunction

   function automatic logic [7:0] page0Sum();
      logic [7:0] s;
      s = ZERO_BYTE;
      for (int k = 0; k < P0_SUM_LEN; k++)
         s = s + page0Raw(8'(int'(UPPER_BASE) + k));
      page0Sum = s;
   endfunction

   function automatic logic [15:0] page1Sum();
      logic [15:0] s;
      s = 16'h0000;
      for (int k = 0; k < P1_SUM_LEN; k++)
         s = s + {8'h00, page1Raw(8'(int'(UPPER_BASE) + k))};
      page1Sum = s;
   endfunction

   localparam logic [7:0]  P0_CSUM_VAL = page0Sum();
   localparam logic [15:0] P1_CSUM_VAL = page1Sum();

   orxid_state_t state_q, state_d;
   logic [7:0]   pageSel_q, pageSel_d;
   logic [7:0]   rdData_q, rdData_d;
   logic [3:0]   flags_q, flags_d;
   logic         irqN_q, irqN_d;
   logic [7:0]   upperByte;
   logic [3:0]   crossing;

   // Upper page decode by current page select
   always_comb begin
      upperByte = ZERO_BYTE;
      if (pageSel_q == PAGE_ID_P0) begin
         if (req.addr == P0_CHECKSUM)
            upperByte = P0_CSUM_VAL;
         else if (req.addr >= P0_RSVD_BASE)
            upperByte = RESERVED_FILL;
         else
            upperByte = page0Raw(req.addr);
      end else if (pageSel_q == PAGE_ID_P1) begin
         if (req.addr == P1_CSUM_MSB)
            upperByte = P1_CSUM_VAL[15:8];
         else if (req.addr == P1_CSUM_LSB)
            upperByte = P1_CSUM_VAL[7:0];
         else if (req.addr >= P1_RSVD_BASE)
            upperByte = RESERVED_FILL;
         else
            upperByte = page1Raw(req.addr);
      end
   end

   // Threshold comparison against live monitors
   always_comb begin
      crossing              = 4'h0;
      crossing[ALM_TEMP_HI] = mon.caseTemp > P1_TEMP_HI_VAL;
      crossing[ALM_TEMP_LO] = mon.caseTemp < P1_TEMP_LO_VAL;
      crossing[ALM_VCC_HI]  = mon.supplyVolt > P1_VCC_HI_VAL;
      crossing[ALM_VCC_LO]  = mon.supplyVolt < P1_VCC_LO_VAL;
   end

   always_comb begin
      state_d   = state_q;
      pageSel_d = pageSel_q;
      rdData_d  = rdData_q;
      case (state_q)
         ORXID_IDLE: begin
            if (req.rdEn) begin
               state_d  = ORXID_RESP;
               rdData_d = (req.addr == PAGE_SEL_ADDR) ? pageSel_q :
                          (req.addr >= UPPER_BASE)    ? upperByte : ZERO_BYTE;
            end else if (req.wrEn && req.addr == PAGE_SEL_ADDR) begin
               pageSel_d = req.wrData;
            end
            // Writes to upper pages are dropped
         end
         ORXID_RESP: begin
            state_d = ORXID_IDLE;
         end
         default: state_d = ORXID_IDLE;
      endcase
      // Set wins over clear for the same flag
      flags_d = (flags_q & ~alarmClear) | crossing;
      irqN_d  = ~|(flags_q & ~alarmMask);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q   <= ORXID_IDLE;
         pageSel_q <= PAGE_SEL_RESET;
         rdData_q  <= ZERO_BYTE;
         flags_q   <= 4'h0;
         irqN_q    <= 1'b1;
      end else begin
         state_q   <= state_d;
         pageSel_q <= pageSel_d;
         rdData_q  <= rdData_d;
         flags_q   <= flags_d;
         irqN_q    <= irqN_d;
      end
   end

   assign rdData              = rdData_q;
   assign rdValid             = (state_q == ORXID_RESP);
   assign pageSel             = pageSel_q;
   assign alarmFlags          = flags_q;
   assign alarm_interrupt_low = irqN_q;

endmodule

// ---- testbench/orxid_page_map_assertions.sv ----
`timescale 1ns/1ps
module orxid_page_map_assertions
   import orxid_pkg::*;
(
   input wire logic       clk,                 // Device clock
   input wire logic       srst,                // Synchronous reset
   input wire orxid_req_t req,                 // Byte request
   input wire orxid_mon_t mon,                 // Live monitor values
   input wire logic [3:0] alarmMask,           // Alarm masks
   input wire logic [3:0] alarmClear,          // Alarm clear pulses
   input wire logic [7:0] rdData,              // Read data
   input wire logic       rdValid,             // Read data valid
   input wire logic [7:0] pageSel,             // Page select byte
   input wire logic [3:0] alarmFlags,          // Latched alarm flags
   input wire logic       alarm_interrupt_low  // Interrupt, active low
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic rdTake;
   assign rdTake = req.rdEn && !rdValid;
   page_reset_a: assert property (@(posedge clk) disable iff (1'b0) srst |=> pageSel == 8'h00)
      else $error("page select not cleared by reset");
   read_answer_a: assert property (rdTake |=> rdValid ##1 !rdValid)
      else $error("read answer not a single pulse one cycle later");
   page_write_a: assert property (req.wrEn && !req.rdEn && !rdValid && req.addr == PAGE_SEL_ADDR
      |=> pageSel == $past(req.wrData))
      else $error("page select write not taken");
   page_hold_a: assert property (!(req.wrEn && req.addr == PAGE_SEL_ADDR) |=> $stable(pageSel))
      else $error("page select changed without a write to it");
   reserved_fill_a: assert property (rdTake && pageSel == 8'h00 && req.addr >= 8'he0 |=> rdData == 8'hff)
      else $error("reserved byte of page 0 not all ones");
   temp_thresh_a: assert property (rdTake && pageSel == 8'h01 && req.addr == 8'h80 |=> rdData == 8'h46)
      else $error("high temperature threshold wrong");
   temp_alarm_a: assert property (mon.caseTemp > 8'h46 |=> alarmFlags[3])
      else $error("high temperature flag not raised");
   supply_alarm_a: assert property (mon.supplyVolt < 16'h7a76 |=> alarmFlags[0])
      else $error("low supply flag not raised");
   irq_assert_a: assert property (alarmFlags[3] && !alarmMask[3] |=> !alarm_interrupt_low)
      else $error("unmasked flag did not raise interrupt");
   irq_masked_a: assert property ((alarmFlags & ~alarmMask) == 4'h0 |=> alarm_interrupt_low)
      else $error("interrupt without an unmasked flag");
endmodule

// ---- testbench/orxid_host_model.sv ----
`timescale 1ns/1ps
module orxid_host_model
   import orxid_pkg::*;
(
   input wire logic   clk,  // Device clock
   output orxid_req_t req   // Byte request to device
);
   initial req = '0;
   // One access: strobe over one edge, released over the answer edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
      @(negedge clk);
      req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
   endtask
endmodule

// ---- testbench/orxid_page_map_test.sv ----
`timescale 1ns/1ps
module orxid_page_map_test;
   import orxid_pkg::*;
   localparam logic [23:0]  OUI = 24'h5a3c11;           // Arbitrary value
   localparam logic [15:0]  LEN = 16'h0103;
   localparam logic [127:0] NM  = "NEUTRAL VENDOR  ";   // Arbitrary value
   localparam logic [127:0] PN  = "RXPART-0042     ";   // Arbitrary value
   localparam logic [15:0]  RV  = "B2";
   localparam logic [127:0] SN  = "SER12345        ";
   localparam logic [63:0]  DT  = "20230915";
   localparam logic [79:0]  LT  = "L77       ";
   localparam logic [567:0] TXT = {NM, OUI, PN, RV, SN, DT, LT};
   logic        clk;
   logic        srst;
   orxid_req_t  req;
   orxid_mon_t  mon;
   logic [3:0]  alarmMask;
   logic [3:0]  alarmClear;
   logic [3:0]  alarmFlags;
   logic [7:0]  rdData;
   logic [7:0]  pageSel;
   logic        rdValid;
   logic        alarm_interrupt_low;
   int          mismatches;
   int          n_compared;
   logic [7:0]  expq[$];
   logic [7:0]  s0;
   logic [15:0] s1;

   orxid_host_model u_host (.clk(clk), .req(req));
   orxid_page_map #(.VENDOR_COMPANY_ID(OUI), .CABLE_LEN(LEN), .CONNECTOR(CONN_PIGTAIL), .VENDOR_NAME(NM),
      .PART_NUM(PN), .REVISION(RV), .SERIAL_NUM(SN), .DATE_CODE(DT), .LOT_CODE(LT)) u_dut (
      .clk(clk), .srst(srst), .req(req), .mon(mon), .alarmMask(alarmMask), .alarmClear(alarmClear),
      .rdData(rdData), .rdValid(rdValid), .pageSel(pageSel), .alarmFlags(alarmFlags),
      .alarm_interrupt_low(alarm_interrupt_low));

   function automatic logic [7:0] exp0(input logic [7:0] a);
      if (a >= 8'h98 && a <= 8'hde) return TXT[8*(222-a) +: 8];
      if (a >= 8'he0) return 8'hff;
      case (a)
         8'h81: return 8'h60;
         8'h82: return 8'h81;
         8'h83: return 8'h80;
         8'h84: return 8'h46;
         8'h85: return 8'h19;
         8'h86: return 8'h8d;
         8'h87: return 8'h42;
         8'h88: return 8'h68;
         8'h89: return 8'h07;
         8'h8a: return 8'hd0;
         8'h8b: return 8'h50;
         8'h8c: return 8'h1b;
         8'h8d: return 8'h20;
         8'h90: return 8'ha0;
         8'h94: return 8'h12;
         8'h95: return 8'h9e;
         8'h96: return LEN[15:8];
         8'h97: return LEN[7:0];
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] exp1(input logic [7:0] a);
      if (a >= 8'hb6) return 8'hff;
      case (a)
         8'h80: return 8'h46;
         8'h90: return 8'h87;
         8'h91: return 8'h5a;
         8'h92: return 8'h7a;
         8'h93: return 8'h76;
         default: return 8'h00;
      endcase
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      u_host.xfer(1'b0, a, 8'h00);
   endtask

   // Drive monitors, masks and a clear pulse, then check flags and interrupt
   task automatic step(input logic [7:0] t, input logic [15:0] v, input logic [3:0] m, input logic [3:0] c,
                       input logic [3:0] ef, input logic ei);
      @(negedge clk);
      mon <= '{caseTemp: t, supplyVolt: v};
      alarmMask <= m;
      alarmClear <= c;
      @(negedge clk);
      alarmClear <= 4'h0;
      repeat (2) @(negedge clk);
      chk({4'h0, alarmFlags}, {4'h0, ef});
      chk({7'h0, alarm_interrupt_low}, {7'h0, ei});
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #250000;
      mismatches++;
      print_verdict();
   end

   always @(negedge clk) begin
      if (rdValid === 1'b1) begin
         if (expq.size() == 0) chk(rdData, 8'hxx);
         else chk(rdData, expq.pop_front());
      end
   end

   initial begin
      srst = 1'b1;
      mon = '{caseTemp: 8'h20, supplyVolt: 16'h8000};
      alarmMask = 4'h0;
      alarmClear = 4'h0;
      mismatches = 0;
      n_compared = 0;
      s0 = 8'h00;
      s1 = 16'h0000;
      void'($urandom(32'h6714));
      repeat (3) @(negedge clk);
      srst = 1'b0;
      chk(pageSel, 8'h00);
      for (int a = 128; a < 223; a++) s0 += exp0(8'(a));
      for (int a = 128; a < 180; a++) s1 += 16'(exp1(8'(a)));
      for (int a = 128; a < 256; a++) begin
         u_host.xfer(1'b1, 8'(a), 8'($urandom));
         rd(8'(a), (a == 223) ? s0 : exp0(8'(a)));
      end
      rd(8'($urandom_range(126, 0)), 8'h00);
      u_host.xfer(1'b1, PAGE_SEL_ADDR, 8'h01);
      chk(pageSel, 8'h01);
      for (int a = 128; a < 256; a++)
         rd(8'(a), (a == 180) ? s1[15:8] : (a == 181) ? s1[7:0] : exp1(8'(a)));
      u_host.xfer(1'b1, PAGE_SEL_ADDR, 8'h02);
      rd(8'h81, 8'h00);
      u_host.xfer(1'b1, PAGE_SEL_ADDR, 8'h00);
      rd(8'h81, 8'h60);
      step(8'h46, 16'h875a, 4'h0, 4'hf, 4'h0, 1'b1);
      step(8'h47, 16'h7a76, 4'h0, 4'h0, 4'h8, 1'b0);
      step(8'h50, 16'h7a76, 4'h8, 4'h0, 4'h8, 1'b1);
      step(8'h20, 16'h875b, 4'h8, 4'h8, 4'h2, 1'b0);
      step(8'h20, 16'h7a75, 4'h3, 4'h2, 4'h1, 1'b1);
      step(8'h20, 16'h8000, 4'h0, 4'hf, 4'h0, 1'b1);
      repeat (4) @(negedge clk);
      chk(8'(expq.size()), 8'h00);
      print_verdict();
   end
endmodule

bind orxid_page_map orxid_page_map_assertions u_chk (.clk(clk), .srst(srst), .req(req), .mon(mon),
   .alarmMask(alarmMask), .alarmClear(alarmClear), .rdData(rdData), .rdValid(rdValid), .pageSel(pageSel),
   .alarmFlags(alarmFlags), .alarm_interrupt_low(alarm_interrupt_low));
